// ===== src/pio_cell.sv
// Purpose: Programmable I/O register cell with input, output and tri-state blocks
// Assumes: Mode ports are static configuration; cell edge fixed by parameter
// Notes:   Pad output and tri-state control are combinational muxes by nature
//
// Contract
// - Bypass path gives pad straight to core as data and as clock.
// - Selectable fixed lag; bottom-edge cells also take a five-bit lag code.
// - Single-rate input captures the pad in one system-clock register.
// - Generic double-rate input samples on rising and falling system edges.
// - Rising capture on first output; single-rate and falling capture on second.
// - Memory double-rate input, right edge only, captures on both read strobe edges.
// - Memory double-rate streams pass system-clock sync registers before the core.
// - Sync registers use the system edge chosen by polarity select.
// - Read and write strobe inputs are the shifted memory strobes.
// - Shifted strobes and polarity select exist only on right-edge cells.
// - Single-rate output uses one element, register or transparent latch.
// - Generic double-rate output registers both rising, second refiled falling.
// - Generic double-rate mux alternates the two registers on the system clock.
// - Memory double-rate output registers both rising, second refiled falling.
// - Memory double-rate mux is steered by the shifted write strobe.
// - Tri-state block gives a registered or passed enable to the buffer.
// - Input, output and tri-state blocks share one system clock.
// - Local set/reset forces all registers but the strobe-side and polarity sync ones to their initial state.

`timescale 1ns/1ps
`default_nettype none

module pio_cell
    import pio_cell_pkg::*;
#(
    parameter cell_edge_t      CELL_EDGE  = EDGE_RIGHT,
    parameter logic            INIT_VALUE = INIT_DEF,
    parameter logic [4:0]      FIXED_LAG  = FIXED_LAG_DEF
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic                    lsr,
    input  wire pio_cell_pkg::in_mode_t  in_mode,
    input  wire pio_cell_pkg::out_mode_t out_mode,
    input  wire pio_cell_pkg::lag_mode_t lag_mode,
    input  wire logic                    oe_registered,
    input  wire logic [4:0]              input_lag_code,
    input  wire logic                    read_strobe_shifted,
    input  wire logic                    write_strobe_shifted,
    input  wire logic                    sync_polarity_select,
    input  wire logic                    pad_in,
    output logic                         pad_out,
    output logic                         pad_tristate_ctl,
    input  wire pio_cell_pkg::core_out_t core_out,
    input  wire logic                    core_output_enable,
    output logic                         bypass_comb_in,
    output logic                         bypass_clock_in,
    output logic                         rise_capture_out,
    output logic                         fall_capture_out
);
    import pio_cell_pkg::*;

    localparam logic IS_RIGHT  = (CELL_EDGE == EDGE_RIGHT);
    localparam logic IS_BOTTOM = (CELL_EDGE == EDGE_BOTTOM);

    in_mode_t   in_eff;
    out_mode_t  out_eff;
    logic [4:0] lag_sel;
    logic       lag_data;
    logic       rd_strobe;
    logic       wr_strobe;
    logic       pol_sel;
    cap_pair_t  mem_pair;
    logic       rise_out_r;
    logic       fall_out_r;
    logic       fall_neg_r;
    logic       q0_r;
    logic       q1_pre_r;
    logic       q1_r;
    logic       lat_q;
    logic       oe_r;

    // Memory strobes only reach right-edge cells
    assign rd_strobe = IS_RIGHT ? read_strobe_shifted : 1'h0;
    assign wr_strobe = IS_RIGHT ? write_strobe_shifted : 1'h0;
    assign pol_sel   = IS_RIGHT ? sync_polarity_select : 1'h0;

    // Memory modes fall back to generic off the right edge
    always_comb begin
        in_eff  = in_mode;
        out_eff = out_mode;
        if (!IS_RIGHT && in_mode == IN_DDR_MEM) begin
            in_eff = IN_DDR_GEN;
        end
        if (!IS_RIGHT && out_mode == OUT_DDR_MEM) begin
            out_eff = OUT_DDR_GEN;
        end
    end

    // Bypass path
    assign bypass_comb_in  = pad_in;
    assign bypass_clock_in = pad_in;

    // Lag tap choice; dynamic code honoured on bottom edge only
    always_comb begin
        unique case (lag_mode)
            LAG_NONE:    lag_sel = LAG_ZERO;
            LAG_FIXED:   lag_sel = FIXED_LAG;
            LAG_DYNAMIC: lag_sel = IS_BOTTOM ? input_lag_code : FIXED_LAG;
            default:     lag_sel = LAG_ZERO;
        endcase
    end

    lag_line #(
        .TAPS       (LAG_TAPS),
        .INIT_VALUE (INIT_VALUE)
    ) u_lag (
        .clk  (ref_clk),
        .rst  (rst),
        .lsr  (lsr),
        .ce   (ce),
        .din  (pad_in),
        .sel  (lag_sel),
        .dout (lag_data)
    );

    strobe_capture #(
        .INIT_VALUE (INIT_VALUE)
    ) u_strobe (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .lsr        (lsr),
        .ce         (ce),
        .strobe_clk (rd_strobe),
        .pol_async  (pol_sel),
        .din        (lag_data),
        .synced     (mem_pair)
    );

    // Falling-edge input capture for generic double rate
    always_ff @(negedge ref_clk) begin
        if (rst || lsr) begin
            fall_neg_r <= INIT_VALUE;
        end else if (ce) begin
            fall_neg_r <= lag_data;
        end
    end

    // Rising-edge input capture, first core-facing output
    always_ff @(posedge ref_clk) begin
        if (rst || lsr) begin
            rise_out_r <= INIT_VALUE;
        end else if (ce) begin
            unique case (in_eff)
                IN_SDR:     rise_out_r <= rise_out_r;
                IN_DDR_GEN: rise_out_r <= lag_data;
                IN_DDR_MEM: rise_out_r <= mem_pair.rise;
                default:    rise_out_r <= rise_out_r;
            endcase
        end
    end

    // Second core-facing output: single-rate or falling capture
    always_ff @(posedge ref_clk) begin
        if (rst || lsr) begin
            fall_out_r <= INIT_VALUE;
        end else if (ce) begin
            unique case (in_eff)
                IN_SDR:     fall_out_r <= lag_data;
                IN_DDR_GEN: fall_out_r <= fall_neg_r;
                IN_DDR_MEM: fall_out_r <= mem_pair.fall;
                default:    fall_out_r <= fall_out_r;
            endcase
        end
    end

    assign rise_capture_out = rise_out_r;
    assign fall_capture_out = fall_out_r;

    // Output first stage on the rising edge
    always_ff @(posedge ref_clk) begin
        if (rst || lsr) begin
            q0_r     <= INIT_VALUE;
            q1_pre_r <= INIT_VALUE;
        end else if (ce) begin
            q0_r     <= core_out.first;
            q1_pre_r <= core_out.second;
        end
    end

    // Second value refiled on the following falling edge
    always_ff @(negedge ref_clk) begin
        if (rst || lsr) begin
            q1_r <= INIT_VALUE;
        end else if (ce) begin
            q1_r <= q1_pre_r;
        end
    end

    // Single-rate latch, transparent while the clock is high
    always_latch begin
        if (rst || lsr) begin
            lat_q <= INIT_VALUE;
        end else if (ref_clk && ce) begin
            lat_q <= core_out.first;
        end
    end

    // Pad output select
    always_comb begin
        unique case (out_eff)
            OUT_SDR_REG:   pad_out = q0_r;
            OUT_SDR_LATCH: pad_out = lat_q;
            OUT_DDR_GEN:   pad_out = ref_clk ? q0_r : q1_r;
            OUT_DDR_MEM:   pad_out = wr_strobe ? q0_r : q1_r;
            default:       pad_out = q0_r;
        endcase
    end

    // Tri-state block
    always_ff @(posedge ref_clk) begin
        if (rst || lsr) begin
            oe_r <= INIT_VALUE;
        end else if (ce) begin
            oe_r <= core_output_enable;
        end
    end

    assign pad_tristate_ctl = oe_registered ? oe_r : core_output_enable;

    // Checks
    chk_sdr_capture: assert property (
        @(posedge ref_clk) disable iff (rst)
        (in_eff == IN_SDR && ce && !lsr) |=> fall_capture_out == $past(lag_data)
    ) else $error("single-rate capture missed the pad sample");

    chk_rise_capture: assert property (
        @(posedge ref_clk) disable iff (rst)
        (in_eff == IN_DDR_GEN && ce && !lsr) |=> rise_capture_out == $past(lag_data)
    ) else $error("rising capture not on first output");

    chk_fall_capture: assert property (
        @(negedge ref_clk) disable iff (rst)
        (in_eff == IN_DDR_GEN && ce && !lsr)
        ##1 (in_eff == IN_DDR_GEN && ce && !lsr)
        |-> fall_capture_out == $past(lag_data)
    ) else $error("falling capture not on second output");

    chk_hold_ce: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!ce && !lsr) |=> $stable(rise_capture_out) && $stable(fall_capture_out)
                          && $stable(q0_r)
    ) else $error("register moved with clock enable low");

    chk_lsr_init: assert property (
        @(posedge ref_clk) disable iff (rst)
        lsr |=> rise_capture_out == INIT_VALUE && fall_capture_out == INIT_VALUE
                && q0_r == INIT_VALUE && oe_r == INIT_VALUE
    ) else $error("local set/reset did not force initial state");

    chk_out_stage: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && !lsr) ##1 (ce && !lsr)
        |-> q0_r == $past(core_out.first) ##0 q1_pre_r == $past(core_out.second)
    ) else $error("output first stage did not take core values");

    chk_gen_mux_high: assert property (
        @(negedge ref_clk) disable iff (rst)
        out_eff == OUT_DDR_GEN |-> pad_out == q0_r
    ) else $error("generic mux not on first register while clock high");

    chk_gen_mux_low: assert property (
        @(posedge ref_clk) disable iff (rst)
        out_eff == OUT_DDR_GEN |-> pad_out == q1_r
    ) else $error("generic mux not on falling register while clock low");

    chk_mem_mux: assert property (
        @(posedge ref_clk) disable iff (rst)
        (IS_RIGHT && out_eff == OUT_DDR_MEM && write_strobe_shifted) |-> pad_out == q0_r
    ) else $error("memory mux not steered by write strobe");

    chk_mem_mux_low: assert property (
        @(posedge ref_clk) disable iff (rst)
        (IS_RIGHT && out_eff == OUT_DDR_MEM && !write_strobe_shifted) |-> pad_out == q1_r
    ) else $error("memory mux not on falling register while write strobe low");

    chk_tri_pass: assert property (
        @(posedge ref_clk) disable iff (rst)
        !oe_registered |-> pad_tristate_ctl == core_output_enable
    ) else $error("passed tri-state control does not follow the core");

    chk_oe_reg: assert property (
        @(posedge ref_clk) disable iff (rst)
        (oe_registered && ce && !lsr) ##1 oe_registered
        |-> pad_tristate_ctl == $past(core_output_enable)
    ) else $error("registered tri-state control lagging wrong");

    chk_sdr_out: assert property (
        @(posedge ref_clk) disable iff (rst)
        (out_eff == OUT_SDR_REG && ce && !lsr) ##1 (out_eff == OUT_SDR_REG)
        |-> pad_out == $past(core_out.first)
    ) else $error("single-rate output register wrong");

endmodule // pio_cell

`default_nettype wire

// ===== src/pio_cell_pkg.sv
// Purpose: Shared types and constants for the programmable I/O register cell
// Assumes: Modes are static configuration driven from the core clock domain
// Notes:   Fixed lag default is a plain starting value, tune per board

package pio_cell_pkg;

    typedef enum logic [1:0] {
        IN_SDR,
        IN_DDR_GEN,
        IN_DDR_MEM
    } in_mode_t;

    typedef enum logic [1:0] {
        OUT_SDR_REG,
        OUT_SDR_LATCH,
        OUT_DDR_GEN,
        OUT_DDR_MEM
    } out_mode_t;

    typedef enum logic [1:0] {
        LAG_NONE,
        LAG_FIXED,
        LAG_DYNAMIC
    } lag_mode_t;

    typedef enum logic [1:0] {
        EDGE_LEFT,
        EDGE_TOP,
        EDGE_BOTTOM,
        EDGE_RIGHT
    } cell_edge_t;

    typedef struct packed {
        logic first;
        logic second;
    } core_out_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } cap_pair_t;

    localparam int                  LAG_CODE_W    = 5;
    localparam int                  LAG_TAPS      = 32;
    localparam logic [4:0]          LAG_ZERO      = 5'h00;
    localparam logic [4:0]          FIXED_LAG_DEF = 5'h04;
    localparam logic                INIT_DEF      = 1'h0;

endpackage

// ===== src/lag_line.sv
// Purpose: Input lag line, a tap chain with indexed tap select
// Assumes: Tap zero passes the pad data without lag
// Notes:   All taps hold while the clock enable is low

`timescale 1ns/1ps
`default_nettype none

module lag_line
    import pio_cell_pkg::*;
#(
    parameter int   TAPS      = LAG_TAPS,
    parameter logic INIT_VALUE = INIT_DEF
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  lsr,
    input  wire logic                  ce,
    input  wire logic                  din,
    input  wire logic [LAG_CODE_W-1:0] sel,
    output logic                       dout
);
    logic [TAPS-1:0] tap_r;

    // Tap chain, one stage per entry
    genvar i;
    generate
        for (i = 0; i < TAPS; i++) begin : g_tap
            always_ff @(posedge clk) begin
                if (rst || lsr) begin
                    tap_r[i] <= INIT_VALUE;
                end else if (ce) begin
                    tap_r[i] <= (i == 0) ? din : tap_r[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate

    // Tap select
    always_comb begin
        if (sel == LAG_ZERO) begin
            dout = din;
        end else begin
            dout = tap_r[sel - 5'h01];
        end
    end

endmodule // lag_line

`default_nettype wire

// ===== src/strobe_capture.sv
// Purpose: Memory double-rate capture on the read strobe and transfer to the system clock
// Assumes: Strobe runs only during reads; polarity select is settled before data arrives
// Notes:   Strobe-side registers carry data and the clock enable and have no reset

`timescale 1ns/1ps
`default_nettype none

module strobe_capture
    import pio_cell_pkg::*;
#(
    parameter logic INIT_VALUE = INIT_DEF
) (
    input  wire logic      ref_clk,
    input  wire logic      rst,
    input  wire logic      lsr,
    input  wire logic      ce,
    input  wire logic      strobe_clk,
    input  wire logic      pol_async,
    input  wire logic      din,
    output cap_pair_t      synced
);
    logic      ce_s1_r;
    logic      ce_s2_r;
    logic      rise_s_r;
    logic      fall_s_r;
    logic      pol_s1_r;
    logic      pol_s2_r;
    cap_pair_t neg_stage_r;
    cap_pair_t synced_r;

    // Clock enable into the strobe domain
    always_ff @(posedge strobe_clk) begin
        ce_s1_r <= ce;
        ce_s2_r <= ce_s1_r;
    end

    // Both strobe edges capture the pad data
    always_ff @(posedge strobe_clk) begin
        if (ce_s2_r) begin
            rise_s_r <= din;
        end
    end

    always_ff @(negedge strobe_clk) begin
        if (ce_s2_r) begin
            fall_s_r <= din;
        end
    end

    // Polarity select into the system domain
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pol_s1_r <= 1'h0;
            pol_s2_r <= 1'h0;
        end else begin
            pol_s1_r <= pol_async;
            pol_s2_r <= pol_s1_r;
        end
    end

    // Falling system edge stage, used when polarity select is high
    always_ff @(negedge ref_clk) begin
        if (rst || lsr) begin
            neg_stage_r <= {INIT_VALUE, INIT_VALUE};
        end else if (ce) begin
            neg_stage_r <= {rise_s_r, fall_s_r};
        end
    end

    // Rising system edge stage picks the path set by polarity
    always_ff @(posedge ref_clk) begin
        if (rst || lsr) begin
            synced_r <= {INIT_VALUE, INIT_VALUE};
        end else if (ce) begin
            synced_r <= pol_s2_r ? neg_stage_r : {rise_s_r, fall_s_r};
        end
    end

    assign synced = synced_r;

endmodule // strobe_capture

`default_nettype wire

// ===== tb/mem_strobe_model.sv
// Purpose: Memory-side model: read strobe burst and data on the pad
// Assumes: Strobe period 30 ns, data centred on each strobe edge
// Notes:   Strobe stands still low between bursts

`timescale 1ns/1ps
`default_nettype none

module mem_strobe_model (
    input  wire logic       go,
    input  wire logic [7:0] pattern,
    output logic            strobe,
    output logic            dq,
    output logic            busy
);
    initial begin
        strobe = 1'b0;
        dq     = 1'b1;
        busy   = 1'b0;
    end

    always @(posedge go) begin
        busy = 1'b1;
        // Preamble: strobe driven low before the first rise
        #15;
        for (int i = 0; i < 8; i++) begin
            dq = pattern[i];
            #7.5;
            // Shifted strobe edge lands a quarter period into the bit
            strobe = ~strobe;
            #7.5;
        end
        // Released line shows no stale value
        dq   = ~dq;
        busy = 1'b0;
    end
endmodule // mem_strobe_model

`default_nettype wire

// ===== tb/test_pio_cell.sv
// Purpose: Self-checking bench for the I/O register cell
// Assumes: Right-edge cell, fixed lag of four taps
// Notes:   Inputs change 1 ns after the clock edge

`timescale 1ns/1ps
`default_nettype none

module test_pio_cell;
    import pio_cell_pkg::*;

    localparam logic [4:0] LAG = 5'h04;

    logic       ref_clk, rst, ce, lsr, oe_reg;
    in_mode_t   in_mode;
    out_mode_t  out_mode;
    lag_mode_t  lag_mode;
    logic [4:0] lag_code;
    logic       ws, pol, tb_pad, use_mem, pad_in, pad_out, tri_ctl;
    core_out_t  core_out;
    logic       oe, comb_in, clk_in, rise_q, fall_q, go, strobe, mem_dq, busy;
    logic [7:0] pattern;
    int         fail_count, checks_done;

    assign pad_in = use_mem ? mem_dq : tb_pad;

    pio_cell #(.CELL_EDGE(EDGE_RIGHT), .INIT_VALUE(1'b0), .FIXED_LAG(LAG)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .lsr(lsr), .in_mode(in_mode),
        .out_mode(out_mode), .lag_mode(lag_mode), .oe_registered(oe_reg),
        .input_lag_code(lag_code), .read_strobe_shifted(strobe),
        .write_strobe_shifted(ws), .sync_polarity_select(pol), .pad_in(pad_in),
        .pad_out(pad_out), .pad_tristate_ctl(tri_ctl), .core_out(core_out),
        .core_output_enable(oe), .bypass_comb_in(comb_in), .bypass_clock_in(clk_in),
        .rise_capture_out(rise_q), .fall_capture_out(fall_q)
    );

    mem_strobe_model u_mem (
        .go(go), .pattern(pattern), .strobe(strobe), .dq(mem_dq), .busy(busy)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Bypass path follows the pad with no clock
    task automatic t_bypass();
        tb_pad = 1'b1;
        #0.5 check(comb_in, 1'b1);
        check(clk_in, 1'b1);
        tb_pad = 1'b0;
        #0.5 check(comb_in, 1'b0);
        check(clk_in, 1'b0);
        step(1);
    endtask

    // Single-rate capture with and without fixed lag
    task automatic t_sdr_in();
        in_mode = IN_SDR;
        tb_pad  = 1'b1;
        step(1);
        check(fall_q, 1'b1);
        check(rise_q, 1'b0);
        // Dynamic code is ignored off the bottom edge, so both modes use the fixed lag
        for (int m = 0; m < 2; m++) begin
            tb_pad   = 1'b0;
            lag_mode = (m == 0) ? LAG_FIXED : LAG_DYNAMIC;
            step(LAG + 2);
            tb_pad = 1'b1;
            step(LAG);
            check(fall_q, 1'b0);
            step(1);
            check(fall_q, 1'b1);
        end
        lag_mode = LAG_NONE;
        step(2);
    endtask

    // Generic double-rate capture, two opposite pairs back to back
    task automatic t_ddr_in();
        in_mode = IN_DDR_GEN;
        step(2);
        for (int i = 0; i < 2; i++) begin
            tb_pad = i[0];
            @(negedge ref_clk) #1 tb_pad = ~i[0];
            step(1);
            // Falling sample from the half before the edge, rising sample at the edge
            check(rise_q, ~i[0]);
            check(fall_q, i[0]);
        end
    endtask

    // Clock enable holds, local set/reset forces the initial value
    task automatic t_ce_lsr();
        in_mode = IN_SDR;
        tb_pad  = 1'b0;
        step(2);
        ce     = 1'b0;
        tb_pad = 1'b1;
        step(3);
        check(fall_q, 1'b0);
        ce = 1'b1;
        step(1);
        check(fall_q, 1'b1);
        lsr = 1'b1;
        step(1);
        check(fall_q, 1'b0);
        check(rise_q, 1'b0);
        lsr = 1'b0;
        step(1);
        check(fall_q, 1'b1);
    endtask

    // Output register, latch, generic and memory double-rate muxing
    task automatic t_out();
        out_mode       = OUT_SDR_REG;
        core_out.first = 1'b1;
        @(negedge ref_clk) #1 check(pad_out, 1'b0);
        step(1);
        check(pad_out, 1'b1);
        out_mode       = OUT_SDR_LATCH;
        core_out.first = 1'b0;
        #0.5 check(pad_out, 1'b0);
        @(negedge ref_clk) #1 core_out.first = 1'b1;
        #0.5 check(pad_out, 1'b0);
        step(1);
        check(pad_out, 1'b1);
        out_mode = OUT_DDR_GEN;
        for (int i = 0; i < 2; i++) begin
            core_out = '{first: i[0], second: ~i[0]};
            step(1);
            check(pad_out, i[0]);
            @(negedge ref_clk) #1 check(pad_out, ~i[0]);
            step(1);
        end
        out_mode = OUT_DDR_MEM;
        core_out = '{first: 1'b1, second: 1'b0};
        step(1);
        @(negedge ref_clk) #1 ws = 1'b1;
        #0.5 check(pad_out, 1'b1);
        step(1);
        check(pad_out, 1'b1);
        ws = 1'b0;
        #0.5 check(pad_out, 1'b0);
        step(1);
    endtask

    // Tri-state control registered, then passed
    task automatic t_tri();
        oe_reg = 1'b1;
        oe     = 1'b0;
        step(2);
        oe = 1'b1;
        #0.5 check(tri_ctl, 1'b0);
        step(1);
        check(tri_ctl, 1'b1);
        oe_reg = 1'b0;
        oe     = 1'b0;
        #0.5 check(tri_ctl, 1'b0);
    endtask

    // Memory double-rate read burst at one sync polarity
    task automatic t_mem(input logic p, input logic [7:0] pat);
        in_mode = IN_DDR_MEM;
        use_mem = 1'b1;
        pol     = p;
        pattern = pat;
        step(4);
        go = 1'b1;
        step(1);
        go = 1'b0;
        for (int i = 0; i <= 200; i++) begin
            if (!busy) break;
            if (i == 200) begin
                fail_count++;
                print_verdict();
            end
            step(1);
        end
        step(6);
        check(rise_q, pat[6]);
        check(fall_q, pat[7]);
    endtask

    initial begin
        fail_count = 0;
        checks_done = 0;
        rst = 1'b1; ce = 1'b1; lsr = 1'b0; oe_reg = 1'b0; oe = 1'b0;
        in_mode = IN_SDR; out_mode = OUT_SDR_REG; lag_mode = LAG_NONE;
        lag_code = 5'h03; ws = 1'b0; pol = 1'b0; tb_pad = 1'b0; use_mem = 1'b0;
        core_out = '{first: 1'b0, second: 1'b0}; go = 1'b0; pattern = 8'h00;
        step(12);
        rst = 1'b0;
        step(1);
        t_bypass();
        t_sdr_in();
        t_ddr_in();
        t_ce_lsr();
        t_out();
        t_tri();
        t_mem(1'b0, 8'hB4);
        t_mem(1'b1, 8'h4B);
        print_verdict();
    end
endmodule // test_pio_cell

`default_nettype wire
